// >>> rtl/acf_pkg.sv
// Purpose: Shared constants and types for the output code formatter
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz clock
// Notes: Register offsets are byte addresses

package acf_pkg;

	// ----------------------------------------
	// Code range
	// ----------------------------------------
	localparam int CODE_W = 14;
	localparam logic [13:0] CODE_MAX = 14'h3fff;
	localparam logic [13:0] CODE_MID = 14'h1fff;
	localparam logic [13:0] CODE_ZERO = 14'h0000;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_COEF_RED = 8'h04;
	localparam logic [7:0] ADDR_COEF_GREEN = 8'h08;
	localparam logic [7:0] ADDR_COEF_BLUE = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int CTRL_W = 9;
	localparam logic [8:0] CTRL_RESET = 9'h080;
	localparam int COEF_W = 16;
	localparam logic [15:0] COEF_RESET = 16'h0000;

	// ----------------------------------------
	// Buffer and latency
	// ----------------------------------------
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_CNT_W = 5;
	localparam int NUM_CHAN = 3;

	typedef enum logic [1:0] {CH_RED, CH_GREEN, CH_BLUE} acf_chan_e;
	typedef enum logic [1:0] {FMT_PAR14, FMT_MUX86, FMT_MUX77, FMT_NIB} acf_fmt_e;
	typedef enum logic [1:0] {PL_BIP0, PL_BIP1, PL_TOP, PL_BOTTOM} acf_place_e;
	typedef enum {REG_CTRL, REG_COEF_R, REG_COEF_G, REG_COEF_B, REG_STATUS, REG_NONE} acf_reg_e;

	// Low bit first: format, invert, placement, latency, double sample, line mode
	typedef struct packed {
		logic line_mode;
		logic double_sample;
		logic [1:0] latency;
		acf_place_e placement;
		logic invert;
		acf_fmt_e format;
	} acf_ctrl_s;

	typedef struct packed {
		logic [7:0] gain;
		logic [7:0] offset;
	} acf_coef_s;

	typedef struct packed {
		logic [13:0] code;
		logic green;
		logic over;
	} acf_word_s;

endpackage

// >>> rtl/acf_formatter.sv
// What this block does
// R1 - Format 00 drives all fourteen code bits at once on the full output bus.
// R2 - Format 01 drives the upper eight bits, then the lower six with green and over-range flags.
// R3 - Format 10 drives seven upper bits plus green flag, then seven lower bits plus over-range.
// R4 - Format 11 drives four nibbles on the top pins, the last being bits 1-0 and both flags.
// R5 - With invert set the code becomes 16383 minus the code, else it passes unchanged.
// R6 - Placement 10 adds 16383 so zero input sits at the top of the range.
// R7 - Placement 11 adds nothing so zero input sits at code zero.
// R8 - Placement 00 or 01 adds 8191 so zero input sits at mid-range.
// R9 - Output words appear after the pixel sync pulse with a two-bit selectable latency.
// R10 - Each result is a fourteen-bit unsigned code before inversion.
// R11 - The double-sampling bit resets to 1 and picks the reset level as reference when set.
// R12 - Each of three channels holds its own eight-bit offset and eight-bit gain code.
// R13 - In line-by-line mode each auto-cycle pulse steps red, green, blue, back to red.
// R14 - The green flag is 1 for green samples and 0 for red or blue ones.
// R15 - The over-range flag is 1 when the word came from an out-of-range input.
// R16 - The placed code saturates to 0 through 16383 before inversion and formatting.
//
// Purpose: Places, clips, inverts and serialises conversion codes to the pixel bus
// Assumes: sample_* comes from logic on clk; sync and auto-cycle pins are asynchronous
// Notes: A 16-word buffer decouples conversion from the sync-framed output
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module acf_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [$clog2(DEPTH):0] count
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != (PW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg];
	assign count = count_reg;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

module acf_formatter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [acf_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [acf_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic signed [15:0] sample_value,
	input wire acf_pkg::acf_chan_e sample_channel,
	input wire logic sample_over_range,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire logic pixel_sync_pulse,
	input wire logic auto_cycle_pin,
	output logic [13:0] op_data,
	output logic op_word_strobe,
	output acf_pkg::acf_chan_e active_channel,
	output acf_pkg::acf_coef_s [2:0] channel_coef,
	output logic reset_level_reference
);
	import acf_pkg::*;

	typedef enum {ST_IDLE, ST_WAIT, ST_SHIFT} acf_state_e;

	acf_ctrl_s ctrl_reg;
	acf_coef_s coef_reg [NUM_CHAN];
	acf_chan_e chan_reg;
	acf_state_e state_reg;
	logic [1:0] wait_reg;
	logic [1:0] phase_reg;
	acf_word_s cur_reg;
	logic sync_m_reg, sync_s_reg, sync_d_reg;
	logic cyc_m_reg, cyc_s_reg, cyc_d_reg;
	logic sync_edge, cyc_edge;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic acf_reg_e reg_decode(input logic [ADDR_W-1:0] a);
		unique case (a)
			ADDR_CTRL: reg_decode = REG_CTRL;
			ADDR_COEF_RED: reg_decode = REG_COEF_R;
			ADDR_COEF_GREEN: reg_decode = REG_COEF_G;
			ADDR_COEF_BLUE: reg_decode = REG_COEF_B;
			ADDR_STATUS: reg_decode = REG_STATUS;
			default: reg_decode = REG_NONE;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	function automatic logic [1:0] last_phase(input acf_fmt_e f);
		unique case (f)
			FMT_PAR14: last_phase = 2'd0;
			FMT_MUX86, FMT_MUX77: last_phase = 2'd1;
			FMT_NIB: last_phase = 2'd3;
		endcase
	endfunction

	function automatic logic [13:0] slice(input acf_fmt_e f, input logic [1:0] p,
			input acf_word_s w);
		slice = '0;
		unique case (f)
			// R1 parallel word
			FMT_PAR14: slice = w.code;
			// R2 eight then six
			FMT_MUX86: slice[13:6] = p[0] ? {w.code[5:0], w.green, w.over} : w.code[13:6];
			// R3 seven and seven
			FMT_MUX77: slice[13:6] = p[0] ? {w.code[6:0], w.over} : {w.code[13:7], w.green};
			// R4 four nibbles
			FMT_NIB: begin
				unique case (p)
					2'd0: slice[13:10] = w.code[13:10];
					2'd1: slice[13:10] = w.code[9:6];
					2'd2: slice[13:10] = w.code[5:2];
					2'd3: slice[13:10] = {w.code[1:0], w.green, w.over};
				endcase
			end
		endcase
	endfunction

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_full_reg, w_full_reg;
	logic do_write;
	acf_reg_e wr_sel;
	logic [FIFO_CNT_W-1:0] fifo_count;

	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign wr_sel = reg_decode(awaddr_reg);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_sel inside {REG_NONE, REG_STATUS}) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// R11 double-sample default
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= acf_ctrl_s'(CTRL_RESET);
		end else if (do_write && wr_sel == REG_CTRL) begin
			ctrl_reg <= acf_ctrl_s'(merge(32'(ctrl_reg), wdata_reg, wstrb_reg)
				>> 0);
		end
	end

	// R12 per-channel coefficients
	always_ff @(posedge clk) begin
		for (int i = 0; i < NUM_CHAN; i++) begin
			if (!rst_n) begin
				coef_reg[i] <= acf_coef_s'(COEF_RESET);
			end else if (do_write && wr_sel == acf_reg_e'(int'(REG_COEF_R) + i)) begin
				coef_reg[i] <= acf_coef_s'(merge(32'(coef_reg[i]), wdata_reg,
					wstrb_reg) >> 0);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (reg_decode(s_axi_araddr))
				REG_CTRL: s_axi_rdata <= 32'(ctrl_reg);
				REG_COEF_R: s_axi_rdata <= 32'(coef_reg[CH_RED]);
				REG_COEF_G: s_axi_rdata <= 32'(coef_reg[CH_GREEN]);
				REG_COEF_B: s_axi_rdata <= 32'(coef_reg[CH_BLUE]);
				REG_STATUS: s_axi_rdata <= {23'h0, fifo_count, 2'h0, chan_reg};
				REG_NONE: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign reset_level_reference = ctrl_reg.double_sample;
	assign active_channel = chan_reg;
	for (genvar g = 0; g < NUM_CHAN; g++) begin : g_coef
		assign channel_coef[g] = coef_reg[g];
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{sync_m_reg, sync_s_reg, sync_d_reg} <= 3'h0;
			{cyc_m_reg, cyc_s_reg, cyc_d_reg} <= 3'h0;
		end else begin
			{sync_m_reg, sync_s_reg, sync_d_reg} <= {pixel_sync_pulse, sync_m_reg, sync_s_reg};
			{cyc_m_reg, cyc_s_reg, cyc_d_reg} <= {auto_cycle_pin, cyc_m_reg, cyc_s_reg};
		end
	end
	assign sync_edge = sync_s_reg && !sync_d_reg;
	assign cyc_edge = cyc_s_reg && !cyc_d_reg;

	// R13 red green blue cycling
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chan_reg <= CH_RED;
		end else if (ctrl_reg.line_mode && cyc_edge) begin
			chan_reg <= (chan_reg == CH_BLUE) ? CH_RED : acf_chan_e'(chan_reg + 2'd1);
		end
	end

	// ----------------------------------------
	// Code placement and polarity
	// ----------------------------------------
	logic signed [17:0] placed;
	logic [13:0] clipped;
	logic clip_hit;
	acf_word_s push_word;
	acf_chan_e word_chan;
	acf_word_s head_word;
	logic head_valid, pop;

	always_comb begin
		// R6 R7 R8 black-level offset
		unique case (ctrl_reg.placement)
			PL_TOP: placed = 18'(sample_value) + 18'(CODE_MAX);
			PL_BOTTOM: placed = 18'(sample_value);
			PL_BIP0, PL_BIP1: placed = 18'(sample_value) + 18'(CODE_MID);
		endcase
		// R16 R10 saturate to unsigned 14 bits
		clip_hit = 1'b1;
		if (placed < 0) begin
			clipped = CODE_ZERO;
		end else if (placed > 18'(CODE_MAX)) begin
			clipped = CODE_MAX;
		end else begin
			clipped = placed[13:0];
			clip_hit = 1'b0;
		end
	end

	assign word_chan = ctrl_reg.line_mode ? chan_reg : sample_channel;
	// R5 optional inversion
	assign push_word.code = ctrl_reg.invert ? CODE_MAX - clipped : clipped;
	// R14 green flag
	assign push_word.green = (word_chan == CH_GREEN);
	// R15 over-range covers clipped codes too
	assign push_word.over = sample_over_range || clip_hit;

	// Full buffer stalls the converter side
	acf_fifo #(.WIDTH($bits(acf_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_data(push_word),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.out_data(head_word),
		.out_valid(head_valid),
		.out_ready(pop),
		.count(fifo_count)
	);

	// ----------------------------------------
	// Sync-framed output sequencer
	// ----------------------------------------
	assign pop = (state_reg == ST_WAIT) && (wait_reg == 2'd0);

	// R9 latency after sync
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			wait_reg <= '0;
			phase_reg <= '0;
			cur_reg <= '0;
			op_data <= '0;
			op_word_strobe <= 1'b0;
		end else begin
			op_word_strobe <= 1'b0;
			unique case (state_reg)
				ST_IDLE: if (sync_edge && head_valid) begin
					state_reg <= ST_WAIT;
					wait_reg <= ctrl_reg.latency;
				end
				ST_WAIT: if (wait_reg != 2'd0) begin
					wait_reg <= wait_reg - 2'd1;
				end else begin
					cur_reg <= head_word;
					op_data <= slice(ctrl_reg.format, 2'd0, head_word);
					op_word_strobe <= 1'b1;
					phase_reg <= 2'd1;
					state_reg <= (last_phase(ctrl_reg.format) == 2'd0) ? ST_IDLE : ST_SHIFT;
				end
				ST_SHIFT: begin
					op_data <= slice(ctrl_reg.format, phase_reg, cur_reg);
					op_word_strobe <= 1'b1;
					phase_reg <= phase_reg + 2'd1;
					if (phase_reg == last_phase(ctrl_reg.format)) begin
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic first_out;
	assign first_out = pop;

	sequence s_two_halves(logic [7:0] a, logic [7:0] b);
		op_word_strobe && op_data[13:6] == a ##1 op_word_strobe && op_data[13:6] == b;
	endsequence

	a_parallel_word: assert property (first_out && ctrl_reg.format == FMT_PAR14 // R1
		|=> op_word_strobe && op_data == $past(head_word.code) ##1 !op_word_strobe)
		else $error("parallel word wrong");
	a_eight_six_split: assert property (first_out && ctrl_reg.format == FMT_MUX86 // R2
		|=> s_two_halves(cur_reg.code[13:6], {cur_reg.code[5:0], cur_reg.green, cur_reg.over}))
		else $error("8+6 split wrong");
	a_seven_seven_split: assert property (first_out && ctrl_reg.format == FMT_MUX77 // R3
		|=> s_two_halves({cur_reg.code[13:7], cur_reg.green}, {cur_reg.code[6:0], cur_reg.over}))
		else $error("7+7 split wrong");
	a_nibble_last: assert property (first_out && ctrl_reg.format == FMT_NIB // R4
		|=> op_data[13:10] == cur_reg.code[13:10] ##3
		op_word_strobe && op_data[13:10] == {cur_reg.code[1:0], cur_reg.green, cur_reg.over})
		else $error("nibble sequence wrong");
	a_invert_sum: assert property (sample_valid && !clip_hit // R5
		&& ctrl_reg.placement inside {PL_BIP0, PL_BIP1} |-> 18'(push_word.code) == (ctrl_reg.invert
		? 18'(CODE_MAX) - 18'(CODE_MID) - 18'(sample_value) : 18'(sample_value) + 18'(CODE_MID)))
		else $error("inversion wrong");
	a_top_place: assert property (sample_value == 0 && ctrl_reg.placement == PL_TOP // R6
		&& !ctrl_reg.invert |-> push_word.code == CODE_MAX) else $error("top placement wrong");
	a_zero_place: assert property (sample_value == 0 && ctrl_reg.placement == PL_BOTTOM // R7
		&& !ctrl_reg.invert |-> push_word.code == CODE_ZERO) else $error("zero placement wrong");
	a_mid_place: assert property (sample_value == 0 && !ctrl_reg.invert // R8
		&& ctrl_reg.placement inside {PL_BIP0, PL_BIP1} |-> push_word.code == CODE_MID)
		else $error("mid placement wrong");
	a_latency_zero: assert property (sync_edge && state_reg == ST_IDLE && head_valid // R9
		&& ctrl_reg.latency == 2'd0 |-> ##1 !op_word_strobe ##1 op_word_strobe)
		else $error("latency wrong");
	a_clip_low: assert property (placed < 0 |-> clipped == CODE_ZERO && push_word.over) // R16
		else $error("saturation wrong");
	a_cycle_order: assert property (ctrl_reg.line_mode && cyc_edge && chan_reg == CH_BLUE // R13
		|=> chan_reg == CH_RED) else $error("auto-cycle order wrong");
	a_green_flag: assert property (sample_valid && !ctrl_reg.line_mode // R14
		|-> push_word.green == (sample_channel == CH_GREEN))
		else $error("green flag lost");
	a_reset_default: assert property ($past(!rst_n) |-> reset_level_reference) // R11
		else $error("double-sample default wrong");
endmodule

// >>> test/acf_capture.sv
// Purpose: Scanner-side capture that rebuilds pixel words from output slices
// Assumes: Format input mirrors the format field last written to the block
// Notes: A word closes at the first cycle without strobe or at a fifth slice, which is dropped
`timescale 1ns/1ps

module acf_capture (
	input wire logic clk,
	input wire logic rst_n,
	input wire acf_pkg::acf_fmt_e fmt,
	input wire logic [13:0] op_data,
	input wire logic op_word_strobe,
	output acf_pkg::acf_word_s word,
	output logic [2:0] slices,
	output logic done
);
	import acf_pkg::*;

	logic [13:0] s [4];
	logic [2:0] k;

	// ----------------------------------------
	// Slice capture
	// ----------------------------------------
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (!rst_n) begin
			k <= 3'h0;
			slices <= 3'h0;
		end else if (op_word_strobe && k < 3'h4) begin
			s[k[1:0]] <= op_data;
			k <= k + 3'h1;
		end else if (k != 3'h0) begin
			slices <= k;
			done <= 1'b1;
			k <= 3'h0;
		end
	end

	// ----------------------------------------
	// Reassembly
	// ----------------------------------------
	always_comb begin
		word = '0;
		case (fmt)
			FMT_PAR14: word.code = s[0];
			FMT_MUX86: word = {s[0][13:6], s[1][13:6]};
			FMT_MUX77: word = {s[0][13:7], s[1][13:7], s[0][6], s[1][6]};
			default: word = {s[0][13:10], s[1][13:10], s[2][13:10], s[3][13:10]};
		endcase
	end
endmodule

// >>> test/acf_formatter_tb.sv
// Purpose: Self-checking bench for the output code formatter
// Assumes: Register bus answers within the watchdog span
// Notes: Latency is checked relative to the latency-0 word
`timescale 1ns/1ps

module acf_formatter_tb;
	import acf_pkg::*;

	logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic signed [15:0] sample_value;
	acf_chan_e sample_channel, active_channel;
	logic sample_over_range, sample_valid, sample_ready, pixel_sync_pulse, auto_cycle_pin;
	logic op_word_strobe, reset_level_reference, done;
	logic [13:0] op_data;
	acf_coef_s [2:0] channel_coef;
	acf_fmt_e fmt;
	acf_word_s word;
	logic [2:0] slices;
	logic [14:0] e;
	int error_cnt = 0;
	int checks = 0;
	int base_lat, lat, pl, n;
	int vals [8] = '{0, 0, 0, 50, 12000, -9000, 777, -1};
	int nsl [4] = '{1, 2, 2, 4};

	acf_formatter dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_value,
		.sample_channel, .sample_over_range, .sample_valid, .sample_ready, .pixel_sync_pulse,
		.auto_cycle_pin, .op_data, .op_word_strobe, .active_channel, .channel_coef,
		.reset_level_reference);
	acf_capture cap (.clk, .rst_n, .fmt, .op_data, .op_word_strobe, .word, .slices, .done);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic close_out;
		$display("Counts: %0d checks, %0d mismatches", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			if (tb) chk("bresp", 32'(s_axi_bresp), 32'(er));
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tr;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			if (tr) chk("rdata", s_axi_rdata, ed);
			if (tr) chk("rresp", 32'(s_axi_rresp), 32'(er));
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end
	endtask

	task automatic push(input int v, input int ch, input logic ov);
		logic tk;
		@(posedge clk);
		sample_value <= 16'(v);
		sample_channel <= acf_chan_e'(ch);
		sample_over_range <= ov;
		sample_valid <= 1'b1;
		tk = 1'b0;
		while (!tk) begin
			@(negedge clk);
			tk = sample_ready;
			@(posedge clk);
		end
		sample_valid <= 1'b0;
	endtask

	// Sync pulse held two clocks so the pin synchroniser cannot miss it
	task automatic get_word(output int lt);
		int m;
		@(posedge clk);
		pixel_sync_pulse <= 1'b1;
		lt = 0;
		while (op_word_strobe !== 1'b1 && lt < 40) begin
			@(posedge clk);
			if (lt == 1) pixel_sync_pulse <= 1'b0;
			lt++;
			#1;
		end
		m = 0;
		while (done !== 1'b1 && m < 40) begin
			@(posedge clk);
			m++;
			#1;
		end
		chk("word done", 32'(done), 32'h1);
	endtask

	function automatic logic [14:0] exp_code(input int p, input logic inv, input int v,
		input logic ov);
		int s;
		logic o;
		s = v + (p == 2 ? 16383 : p == 3 ? 0 : 8191);
		o = ov || s > 16383 || s < 0;
		if (s > 16383) s = 16383;
		if (s < 0) s = 0;
		if (inv) s = 16383 - s;
		return {14'(s), o};
	endfunction

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#200000;
		error_cnt++;
		$display("Watchdog expired");
		close_out();
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{sample_value, sample_over_range, sample_valid, pixel_sync_pulse, auto_cycle_pin} = '0;
		sample_channel = CH_RED;
		fmt = FMT_PAR14;
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_CTRL, 32'h80, RESP_OKAY);
		chk("ref level", 32'(reset_level_reference), 32'h1);
		for (int c = 0; c < 3; c++) wr(ADDR_COEF_RED + 8'(4 * c), 32'h215a + c * 32'h10ff, RESP_OKAY);
		for (int c = 0; c < 3; c++) begin
			chk("coef port", 32'(channel_coef[c]), 32'h215a + c * 32'h10ff);
			rd(ADDR_COEF_RED + 8'(4 * c), 32'h215a + c * 32'h10ff, RESP_OKAY);
		end
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		@(posedge clk);
		#1;
		chk("ref level", 32'(reset_level_reference), 32'h0);
		wr(ADDR_STATUS, 32'h0, RESP_SLVERR);
		rd(8'h14, 32'h0, RESP_SLVERR);
		$display("registers done");
		for (int i = 0; i < 8; i++) begin
			pl = (i * 3) % 4;
			fmt <= acf_fmt_e'(i % 4);
			wr(ADDR_CTRL, 32'h80 | (i % 4) << 5 | pl << 3 | (i >= 4) << 2 | (i % 4), RESP_OKAY);
			push(vals[i], i % 3, i == 5);
			get_word(lat);
			if (i == 0) base_lat = lat;
			e = exp_code(pl, i >= 4, vals[i], i == 5);
			chk("latency", 32'(lat - base_lat), 32'(i % 4));
			chk("slices", 32'(slices), 32'(nsl[i % 4]));
			chk("code", 32'(word.code), 32'(e[14:1]));
			if (i % 4 != 0) chk("flags", {word.green, word.over}, {i % 3 == 1, e[0]});
			$display("format case %0d done", i);
		end
		wr(ADDR_CTRL, 32'h98, RESP_OKAY);
		fmt <= FMT_PAR14;
		for (int i = 0; i < 16; i++) push(i * 100 + 1, 0, 1'b0);
		@(negedge clk);
		chk("ready when full", 32'(sample_ready), 32'h0);
		rd(ADDR_STATUS, 32'h100, RESP_OKAY);
		for (int i = 0; i < 16; i++) begin
			get_word(lat);
			chk("drain code", 32'(word.code), 32'(i * 100 + 1));
		end
		@(posedge clk);
		pixel_sync_pulse <= 1'b1;
		repeat (2) @(posedge clk);
		pixel_sync_pulse <= 1'b0;
		n = 0;
		repeat (20) begin
			@(posedge clk);
			#1;
			n += op_word_strobe;
		end
		chk("empty sync", 32'(n), 32'h0);
		$display("buffer done");
		wr(ADDR_CTRL, 32'h199, RESP_OKAY);
		fmt <= FMT_MUX86;
		for (int c = 1; c <= 3; c++) begin
			@(posedge clk);
			auto_cycle_pin <= 1'b1;
			repeat (3) @(posedge clk);
			auto_cycle_pin <= 1'b0;
			repeat (6) @(posedge clk);
			#1;
			chk("active channel", 32'(active_channel), 32'(c % 3));
			rd(ADDR_STATUS, 32'(c % 3), RESP_OKAY);
			if (c == 1) push(5, 0, 1'b0);
			if (c == 1) get_word(lat);
			if (c == 1) chk("line green", 32'(word.green), 32'h1);
		end
		$display("line mode done");
		close_out();
	end
endmodule
